/* File: rtl/qcr_pkg.sv */
/*
  Constants for the quad-enable and continuous-read control block:
  command codes, mode-byte values, phase lengths and the parameter dword
  returned from the discoverable-parameter space.
  Assumes a serial flash front end clocked by the serial bus clock.
*/
package qcr_pkg;

  // Command codes
  localparam logic [7:0] OP_RD_STAT  = 8'h05;
  localparam logic [7:0] OP_RD_CFG   = 8'h35;
  localparam logic [7:0] OP_WR_STAT  = 8'h01;
  localparam logic [7:0] OP_RD_SFDP  = 8'h5A;
  localparam logic [7:0] OP_QIO_READ = 8'hEB;

  // Register bit positions
  localparam int QE_BIT   = 1;
  localparam int BUSY_BIT = 0;

  // Mode byte handling
  localparam logic [7:0] MODE_ENTER = 8'hA5;
  localparam logic [3:0] MODE_NIB   = 4'hA;
  localparam logic [7:0] MODE_EXIT  = 8'h00;
  localparam logic [3:0] RESET_NIB  = 4'hF;
  localparam logic [4:0] RESET_CLKS = 5'h08;

  // Phase end counts, one less than the phase length in clocks
  localparam logic [4:0] OPC_BITS   = 5'h07;
  localparam logic [4:0] ADDR_BITS  = 5'h17;
  localparam logic [4:0] WR_BITS    = 5'h0F;
  localparam logic [4:0] SFDP_DUMMY = 5'h07;
  localparam logic [4:0] ADDR_NIBS  = 5'h05;
  localparam logic [4:0] Q_DUMMY    = 5'h03;

  // Parameter dword 15 fields
  localparam logic [7:0] DW15_RFU     = 8'hFF;
  localparam logic       HOLD_WP_DIS  = 1'b0;
  localparam logic [2:0] QE_REQ       = 3'b101;
  localparam logic [3:0] M044_ENTRY   = 4'b1101;
  localparam logic [5:0] M044_EXIT    = 6'b11_1101;
  localparam logic       M044_SUPPORT = 1'b1;
  localparam logic [4:0] M444_ENABLE  = 5'b0_0000;
  localparam logic [3:0] M444_DISABLE = 4'b0000;
  localparam logic [31:0] SFDP_DW15 = {DW15_RFU, HOLD_WP_DIS, QE_REQ,
    M044_ENTRY, M044_EXIT, M044_SUPPORT, M444_ENABLE, M444_DISABLE};
  localparam logic [7:0] SFDP_BASE = 8'h38;
  localparam logic [7:0] SFDP_FILL = 8'hFF;

  typedef enum logic [3:0] {
    ST_OPCODE, ST_STAT_OUT, ST_CFG_OUT, ST_WR_DATA, ST_SFDP_ADDR,
    ST_SFDP_DUMMY, ST_SFDP_OUT, ST_Q_ADDR, ST_Q_MODE, ST_Q_DUMMY,
    ST_Q_OUT, ST_IGNORE
  } qcr_state_t;

endpackage

/* File: rtl/qcr_ctl.sv */
/*
  Quad-enable and continuous 0-4-4 read control for a serial flash:
  status and configuration register reads, two-byte status write,
  discoverable-parameter dword 15, quad I/O read with mode byte.
  Assumes chip select and data lines are synchronous to clock, the
  host drives on the falling edge, and the array answers array_data
  combinationally for read_addr.
*/
module qcr_ctl
  import qcr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        chip_select_n,
  input  wire logic [3:0]  quad_data_lines_in,
  output logic      [3:0]  quad_data_lines_out,
  output logic      [3:0]  quad_data_lines_oe_n,
  input  wire logic        operation_in_progress_flag,
  input  wire logic [7:0]  array_data,
  output logic      [23:0] read_addr,
  output logic             quad_io_enable_bit,
  output logic             cont_read_mode
);
  import qcr_pkg::*;

  function automatic logic [7:0] sfdp_byte(input logic [7:0] a);
    if (a[7:2] == SFDP_BASE[7:2])
      return SFDP_DW15[{a[1:0], 3'b000} +: 8];
    return SFDP_FILL;
  endfunction

  qcr_state_t  state_r, state_nxt;
  logic [4:0]  cnt_r, cnt_nxt;
  logic [23:0] sh_r;
  logic [23:0] addr_r;
  logic [7:1]  sr1_r;
  logic [7:0]  cfg1_r;
  logic        cont_r, cont_pend_r, mode_seen_r, ones_r;
  logic [3:0]  dout_r, oe_n_r;

  // Decode of incoming bits and phase ends
  wire         si         = quad_data_lines_in[0];
  wire [23:0]  sh_ser     = {sh_r[22:0], si};
  wire [23:0]  sh_quad    = {sh_r[19:0], quad_data_lines_in};
  wire [7:0]   opcode     = sh_ser[7:0];
  wire [7:0]   status1    = {sr1_r, operation_in_progress_flag};
  wire [2:0]   bit_idx    = ~cnt_r[2:0];
  wire         byte_end   = cnt_r[2:0] == 3'h7;
  wire         opc_done   = state_r == ST_OPCODE && cnt_r == OPC_BITS;
  wire         wr_done    = state_r == ST_WR_DATA && cnt_r == WR_BITS;
  wire         mode_done  = state_r == ST_Q_MODE && cnt_r[0];
  wire         all_ones   = quad_data_lines_in == RESET_NIB;
  wire         reset_hit  = mode_done && cont_r && ones_r && all_ones;
  wire [7:0]   mode_byte  = sh_quad[7:0];
  wire         mode_keep  = mode_byte[7:4] == MODE_NIB;
  // Mode as it stands after this cs-high edge commits
  wire         cont_commit = mode_seen_r ? cont_pend_r : cont_r;
  wire [7:0]   sfdp_cur   = sfdp_byte(addr_r[7:0]);
  wire         ser_bit    = state_r == ST_STAT_OUT ? status1[bit_idx] :
                            state_r == ST_CFG_OUT  ? cfg1_r[bit_idx] :
                            sfdp_cur[bit_idx];
  wire         ser_out    = state_r == ST_STAT_OUT ||
                            state_r == ST_CFG_OUT || state_r == ST_SFDP_OUT;
  wire [3:0]   q_nib      = cnt_r[0] ? array_data[3:0] : array_data[7:4];
  wire         q_out      = state_r == ST_Q_OUT;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + 5'h01;
    case (state_r)
      ST_OPCODE: begin
        if (opc_done) begin
          cnt_nxt = 5'h00;
          case (opcode)
            OP_RD_STAT: state_nxt = ST_STAT_OUT;
            OP_RD_CFG:  state_nxt = ST_CFG_OUT;
            OP_WR_STAT: state_nxt = ST_WR_DATA;
            OP_RD_SFDP: state_nxt = ST_SFDP_ADDR;
            OP_QIO_READ: begin
              state_nxt = quad_io_enable_bit ? ST_Q_ADDR : ST_IGNORE;
            end
            default: state_nxt = ST_IGNORE;
          endcase
        end
      end
      ST_WR_DATA: begin
        if (wr_done)
          state_nxt = ST_IGNORE;
      end
      ST_SFDP_ADDR: begin
        if (cnt_r == ADDR_BITS) begin
          state_nxt = ST_SFDP_DUMMY;
          cnt_nxt   = 5'h00;
        end
      end
      ST_SFDP_DUMMY: begin
        if (cnt_r == SFDP_DUMMY) begin
          state_nxt = ST_SFDP_OUT;
          cnt_nxt   = 5'h00;
        end
      end
      ST_Q_ADDR: begin
        if (cnt_r == ADDR_NIBS) begin
          state_nxt = ST_Q_MODE;
          cnt_nxt   = 5'h00;
        end
      end
      ST_Q_MODE: begin
        if (mode_done) begin
          state_nxt = reset_hit ? ST_IGNORE : ST_Q_DUMMY;
          cnt_nxt   = 5'h00;
        end
      end
      ST_Q_DUMMY: begin
        if (cnt_r == Q_DUMMY) begin
          state_nxt = ST_Q_OUT;
          cnt_nxt   = 5'h00;
        end
      end
      ST_STAT_OUT, ST_CFG_OUT, ST_SFDP_OUT, ST_Q_OUT, ST_IGNORE: begin
        cnt_nxt = {2'b00, cnt_r[2:0] + 3'h1};
      end
      default: state_nxt = ST_IGNORE;
    endcase
    if (chip_select_n) begin
      state_nxt = cont_commit ? ST_Q_ADDR : ST_OPCODE;
      cnt_nxt   = 5'h00;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_OPCODE;
      cnt_r   <= 5'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Shift register and read address
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sh_r   <= 24'h00_0000;
      addr_r <= 24'h00_0000;
    end else begin
      sh_r <= (state_r == ST_Q_ADDR || state_r == ST_Q_MODE) ?
              sh_quad : sh_ser;
      if (state_r == ST_SFDP_ADDR && cnt_r == ADDR_BITS)
        addr_r <= sh_ser;
      else if (state_r == ST_Q_ADDR && cnt_r == ADDR_NIBS)
        addr_r <= sh_quad;
      else if ((state_r == ST_SFDP_OUT && byte_end) ||
               (q_out && cnt_r[0]))
        addr_r <= addr_r + 24'h00_0001;
    end
  end

  // Status and configuration write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sr1_r  <= 7'h00;
      cfg1_r <= 8'h00;
    end else if (wr_done && !chip_select_n) begin
      sr1_r  <= sh_r[14:8];
      cfg1_r <= sh_ser[7:0];
    end
  end

  // Continuous read mode tracking
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cont_r      <= 1'b0;
      cont_pend_r <= 1'b0;
      mode_seen_r <= 1'b0;
      ones_r      <= 1'b1;
    end else if (chip_select_n) begin
      ones_r      <= 1'b1;
      mode_seen_r <= 1'b0;
      if (mode_seen_r)
        cont_r <= cont_pend_r;
    end else begin
      if (state_r == ST_Q_ADDR || state_r == ST_Q_MODE)
        ones_r <= ones_r && all_ones;
      if (reset_hit) begin
        cont_r <= 1'b0;
      end else if (mode_done) begin
        cont_pend_r <= mode_keep;
        mode_seen_r <= 1'b1;
      end
    end
  end

  // Output drivers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dout_r <= 4'h0;
      oe_n_r <= 4'hF;
    end else if (chip_select_n) begin
      dout_r <= 4'h0;
      oe_n_r <= 4'hF;
    end else if (q_out) begin
      dout_r <= q_nib;
      oe_n_r <= 4'h0;
    end else if (ser_out) begin
      dout_r <= {2'b00, ser_bit, 1'b0};
      oe_n_r <= 4'hD;
    end else begin
      dout_r <= 4'h0;
      oe_n_r <= 4'hF;
    end
  end

  assign quad_data_lines_out = dout_r;
  assign quad_data_lines_oe_n = oe_n_r;
  assign read_addr           = addr_r;
  assign quad_io_enable_bit  = cfg1_r[QE_BIT];
  assign cont_read_mode      = cont_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_qe_write_stored: assert property (
    wr_done && !chip_select_n && sh_r[0] |=> quad_io_enable_bit)
    else $error("quad enable not set by status write");
  a_qe_write_clear: assert property (
    wr_done && !chip_select_n && !sh_r[0] |=> !quad_io_enable_bit)
    else $error("quad enable not cleared by status write");
  a_qe_gates_quad: assert property (
    opc_done && !chip_select_n && opcode == OP_QIO_READ &&
    !quad_io_enable_bit |=> state_r == ST_IGNORE)
    else $error("quad read accepted with quad enable clear");
  a_cont_mode_entry: assert property (
    chip_select_n && mode_seen_r && cont_pend_r |=> cont_r)
    else $error("continuous mode not entered after mode byte");
  a_mode_byte_noted: assert property (
    mode_done && !reset_hit && !chip_select_n
    |=> mode_seen_r && cont_pend_r == ($past(mode_byte[7:4]) == 4'hA))
    else $error("mode byte not noted for frame end");
  a_cont_mode_exit: assert property (
    chip_select_n && mode_seen_r && !cont_pend_r |=> !cont_r)
    else $error("continuous mode kept after exit mode byte");
  a_exit_zero_byte: assert property (
    mode_done && !chip_select_n && mode_byte == MODE_EXIT
    |=> cont_r == $past(cont_r))
    else $error("continuous mode left before the read ended");
  a_reset_pattern_exit: assert property (
    reset_hit && !chip_select_n |=> !cont_r && state_r == ST_IGNORE)
    else $error("mode bit reset pattern ignored");
  a_cont_skips_opcode: assert property (
    chip_select_n ##1 !chip_select_n
    |-> state_r == (cont_r ? ST_Q_ADDR : ST_OPCODE))
    else $error("continuous frame did not start with address");
  a_status_shift_out: assert property (
    state_r == ST_STAT_OUT && !chip_select_n
    |=> quad_data_lines_out[1] == $past(status1[bit_idx]) &&
        !quad_data_lines_oe_n[1])
    else $error("status register bit mismatch");
  a_busy_bit_out: assert property (
    state_r == ST_STAT_OUT && !chip_select_n && cnt_r[2:0] == 3'h7
    |=> quad_data_lines_out[1] == $past(operation_in_progress_flag))
    else $error("busy flag not returned in bit 0");
  a_config_shift_out: assert property (
    state_r == ST_CFG_OUT && !chip_select_n
    |=> quad_data_lines_out[1] == $past(cfg1_r[bit_idx]))
    else $error("configuration register bit mismatch");
  a_sfdp_dword_bytes: assert property (
    sfdp_byte(8'h38) == 8'h00 && sfdp_byte(8'h39) == 8'hF6 &&
    sfdp_byte(8'h3A) == 8'h5D && sfdp_byte(8'h3B) == 8'hFF)
    else $error("parameter dword bytes wrong");

  c_cont_entered: cover property (mode_done && mode_byte == MODE_ENTER);
  c_reset_pattern: cover property (reset_hit);
  c_sfdp_read: cover property (state_r == ST_SFDP_OUT &&
                               addr_r[7:0] == SFDP_BASE);
  c_status_write: cover property (wr_done && !chip_select_n);

endmodule

/* File: sim/qcr_host.sv */
/*
  Serial bus host model facing the quad control block.
  Assumes the bench calls its tasks at a falling edge and merges the
  host lines with the device drive per line enable.
*/
module qcr_host (
  input  wire logic       clock,
  output logic            chip_select_n,
  output logic      [3:0] host_lines
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    chip_select_n = 1'b1;
    host_lines    = 4'h0;
  end

  // Serial bits on line 0, MSB first
  task automatic tx_bits(input int n, input logic [31:0] v);
    for (int i = n - 1; i >= 0; i--) begin
      chip_select_n = 1'b0;
      host_lines    = {~host_lines[3:1], v[i]};
      @(negedge clock);
    end
  endtask

  // Nibbles on all four lines, MSB first
  task automatic tx_nibs(input int n, input logic [31:0] v);
    for (int i = n - 1; i >= 0; i--) begin
      chip_select_n = 1'b0;
      host_lines    = v[4*i +: 4];
      @(negedge clock);
    end
  endtask

  // Released lines toggle so no stale value survives
  task automatic idle(input int n);
    repeat (n) begin
      host_lines = ~host_lines;
      @(negedge clock);
    end
  endtask

  task automatic finish_frame();
    chip_select_n = 1'b1;
    idle(2);
  endtask
endmodule

/* File: sim/quad_enable_continuous_read_ctl_test.sv */
/*
  Self-checking bench for qcr_ctl: register reads and writes, parameter
  dword read and quad reads with continuous mode entry and exit.
  Assumes qcr_host on the far side and an array of address xor 3Ch.
*/
module quad_enable_continuous_read_ctl_test import qcr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock = 1'b0;
  logic        nrst  = 1'b0;
  logic        busy  = 1'b0;
  logic        cs_n;
  logic [3:0]  host_lines;
  logic [3:0]  dq_in;
  logic [3:0]  dq_out;
  logic [3:0]  dq_oe_n;
  logic [7:0]  array_data;
  logic [23:0] read_addr;
  logic        qe;
  logic        cont;
  logic [7:0]  exp_q[$];
  logic [7:0]  acc;
  int          nbits = 0;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #20 clock = ~clock;
  assign dq_in      = (dq_oe_n & host_lines) | (~dq_oe_n & dq_out);
  assign array_data = read_addr[7:0] ^ 8'h3C;

  qcr_host u_host (.clock(clock), .chip_select_n(cs_n),
    .host_lines(host_lines));

  qcr_ctl u_dut (.clock(clock), .nrst(nrst), .chip_select_n(cs_n),
    .quad_data_lines_in(dq_in), .quad_data_lines_out(dq_out),
    .quad_data_lines_oe_n(dq_oe_n), .operation_in_progress_flag(busy),
    .array_data(array_data), .read_addr(read_addr),
    .quad_io_enable_bit(qe), .cont_read_mode(cont));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Collect device output bytes and match them against the notes
  always @(negedge clock) begin
    // Released lines start a new byte; avoids racing the cs edge
    if (dq_oe_n === 4'hF) begin
      nbits = 0;
    end else if (dq_oe_n === 4'hD) begin
      acc   = {acc[6:0], dq_out[1]};
      nbits += 1;
    end else if (dq_oe_n === 4'h0) begin
      acc   = {acc[3:0], dq_out};
      nbits += 4;
    end
    if (nbits == 8) begin
      nbits = 0;
      if (exp_q.size() == 0) check(acc, ~acc);
      else check(acc, exp_q.pop_front());
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic rd_reg(input logic [7:0] op, input logic [7:0] exp);
    exp_q.push_back(exp);
    u_host.tx_bits(8, op);
    u_host.idle(8);
    u_host.finish_frame();
  endtask

  task automatic wr_stat(input logic [15:0] v);
    u_host.tx_bits(24, {OP_WR_STAT, v});
    u_host.finish_frame();
  endtask

  task automatic q_read(input logic in_cont, input logic [23:0] a,
                        input logic [7:0] mode, input int n);
    if (!in_cont) u_host.tx_bits(8, OP_QIO_READ);
    u_host.tx_nibs(6, a);
    u_host.tx_nibs(2, mode);
    for (int i = 0; i < n; i++) exp_q.push_back(8'(a + i) ^ 8'h3C);
    u_host.idle(4 + 2 * n);
    u_host.finish_frame();
  endtask

  initial begin
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [23:0] a;
    logic [39:0] sfdp;
    sfdp = 40'h00_F6_5D_FF_FF;
    void'($urandom(32'ha457));
    repeat (6) @(negedge clock);
    nrst = 1'b1;
    check({7'h00, qe}, 8'h00);
    check({7'h00, cont}, 8'h00);
    busy = 1'($urandom);
    rd_reg(OP_RD_STAT, {7'h00, busy});
    b1 = 8'($urandom);
    b2 = 8'($urandom) | 8'h02;
    wr_stat({b1, b2});
    check({7'h00, qe}, 8'h01);
    busy = ~busy;
    rd_reg(OP_RD_STAT, {b1[7:1], busy});
    rd_reg(OP_RD_CFG, b2);
    wr_stat({b1, b2 & 8'hFD});
    check({7'h00, qe}, 8'h00);
    rd_reg(OP_RD_CFG, b2 & 8'hFD);
    // Quad read while quad enable is clear must stay silent
    u_host.tx_bits(8, OP_QIO_READ);
    u_host.tx_nibs(8, $urandom);
    u_host.idle(8);
    u_host.finish_frame();
    check({7'h00, cont}, 8'h00);
    // Parameter dword and one byte past its end
    for (int i = 0; i < 5; i++) exp_q.push_back(sfdp[39-8*i -: 8]);
    u_host.tx_bits(32, {OP_RD_SFDP, 24'h00_0038});
    u_host.idle(48);
    u_host.finish_frame();
    wr_stat({b1, b2});
    a = 24'($urandom);
    q_read(1'b0, a, MODE_ENTER, 2);
    check({7'h00, cont}, 8'h01);
    q_read(1'b1, a + 24'h10, {4'hA, 4'($urandom)}, 3);
    check({7'h00, cont}, 8'h01);
    q_read(1'b1, a, 8'h00, 1);
    check({7'h00, cont}, 8'h00);
    q_read(1'b0, a, 8'hA0, 1);
    q_read(1'b1, a, {4'($urandom % 10), 4'($urandom)}, 2);
    check({7'h00, cont}, 8'h00);
    q_read(1'b0, a, 8'hA7, 1);
    u_host.tx_nibs(8, 32'hFFFF_FFFF);
    u_host.idle(6);
    u_host.finish_frame();
    check({7'h00, cont}, 8'h00);
    q_read(1'b0, a, 8'h00, 1);
    check(8'(exp_q.size()), 8'h00);
    print_verdict();
  end
endmodule
